// ---- core/wdpr_defs.svh ----
// Watchdog register offsets, control field positions, reset values and timing figures.
// Assumes inclusion by bare name from the watchdog package and design files.
`ifndef WDPR_DEFS_SVH
`define WDPR_DEFS_SVH

// Register byte offsets on the APB slave.
`define WDPR_CTRL_OFF 8'h00
`define WDPR_STAT_OFF 8'h04
`define WDPR_MASK_OFF 8'h08
`define WDPR_CNT_OFF 8'h0C

// Control register field positions.
`define WDPR_PS_LSB 0
`define WDPR_PS_MSB 2
`define WDPR_IDLE_BIT 4
`define WDPR_RST_EN_BIT 5
`define WDPR_RESTART_BIT 6
`define WDPR_RUN_BIT 7
`define WDPR_HALF_BIT 3

// Status and mask bit positions.
`define WDPR_EV_TIMEOUT 0
`define WDPR_EV_RESTART 1

// Reset values.
`define WDPR_CTRL_RST 8'h00
`define WDPR_MASK_RST 2'h0

// Timing: main counter width and machine-cycle lengths in clocks.
`define WDPR_CNT_BITS 14
`define WDPR_MC_12T 12
`define WDPR_MC_6T 6
`define WDPR_CLK_NS 50

`endif

// ---- core/wdpr_pkg.sv ----
// Types shared by the watchdog design files.
// Assumes the defines header is on the include path.
`include "wdpr_defs.svh"

package wdpr_pkg;
  // Selected machine-cycle base.
  typedef enum logic {
    WDPR_MC_FULL,
    WDPR_MC_HALF
  } wdpr_mc_t;
  // Prescaler select code.
  typedef logic [2:0] wdpr_ps_t;
endpackage

// ---- core/wdpr_prescale.sv ----
// Watchdog prescaler: divides the machine-cycle enable by the selected ratio.
// Assumes a single clock and an in-phase clear from the watchdog core.
`timescale 1ns/1ns
`default_nettype none

module wdpr_prescale (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic clr,
  input wire logic tick_in,
  input wire wdpr_pkg::wdpr_ps_t sel,
  // Output enable pulse.
  output logic tick_out
);
  import wdpr_pkg::*;

  logic [7:0] pre_r;
  logic [7:0] last;

  // Map the select code to the terminal count, 001 and 010 swapped as tabulated.
  always_comb begin
    unique case (sel)
      3'h0: last = 8'h01;
      3'h1: last = 8'h07;
      3'h2: last = 8'h03;
      3'h3: last = 8'h0F;
      3'h4: last = 8'h1F;
      3'h5: last = 8'h3F;
      3'h6: last = 8'h7F;
      3'h7: last = 8'hFF;
    endcase
  end

  // Prescaler counter, cleared by restart or disable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 8'h00;
    end else if (clr) begin
      pre_r <= 8'h00;
    end else if (tick_in) begin
      pre_r <= (pre_r >= last) ? 8'h00 : pre_r + 8'h01;
    end
  end

  assign tick_out = tick_in && (pre_r >= last);
endmodule
`default_nettype wire

// ---- core/wdpr_core.sv ----
// Prescaled watchdog timer with an APB register slave and a reset request output.
// Assumes inputs synchronous to pclk and an outside reset block acting on the request.
//
// Overview of operation
// - Divider chain from system clock; the selected divider output times out.
// - On time-out, request system reset when reset function is enabled.
// - After chip reset the watchdog stays disabled until software enables it.
// - Chip reset clears the watchdog counter to zero.
// - Watchdog runs only while the run-enable bit is one.
// - Writing restart clears counter, prescaler and restart bit next cycle.
// - Idle-run bit keeps watchdog running in idle; resets to zero.
// - Prescale codes: 2, 8, 4, 16, 32, 64, 128, 256.
// - Full mode period is 2^14 times prescale times 12 clocks.
// - Half mode period is half, using a 6-clock machine cycle.
//
// Chosen here: the APB slave port and the register addresses.
`include "wdpr_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module wdpr_core #(
  parameter int CNT_BITS = `WDPR_CNT_BITS
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor state.
  input wire logic cpu_idle,
  // Reset request and interrupt.
  output logic wdt_reset_req,
  output logic wdt_irq
);
  import wdpr_pkg::*;

  logic [7:0] ctrl_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [CNT_BITS-1:0] cnt_r;
  logic [3:0] mc_r;
  logic req_r;
  logic [31:0] prdata_r;
  logic wr_en;
  logic addr_ok;
  logic running;
  logic clr_all;
  logic mc_tick;
  logic pre_tick;
  logic timeout;
  logic restart_ev;
  wdpr_mc_t mc_mode;
  logic [3:0] mc_last;

  // Bus decode: every access completes in its first access cycle.
  assign wr_en = psel && penable && pwrite;
  assign addr_ok = (paddr == `WDPR_CTRL_OFF) || (paddr == `WDPR_STAT_OFF) ||
                   (paddr == `WDPR_MASK_OFF) || (paddr == `WDPR_CNT_OFF);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Run gating: enable bit, and idle only when idle-run is set.
  assign running = ctrl_r[`WDPR_RUN_BIT] &&
                   (!cpu_idle || ctrl_r[`WDPR_IDLE_BIT]);
  assign clr_all = !ctrl_r[`WDPR_RUN_BIT] || ctrl_r[`WDPR_RESTART_BIT];
  assign mc_mode = ctrl_r[`WDPR_HALF_BIT] ? WDPR_MC_HALF : WDPR_MC_FULL;
  assign mc_last = (mc_mode == WDPR_MC_HALF) ? 4'(`WDPR_MC_6T - 1)
                                             : 4'(`WDPR_MC_12T - 1);
  assign mc_tick = running && !clr_all && (mc_r == mc_last);
  assign restart_ev = wr_en && (paddr == `WDPR_CTRL_OFF) && pwdata[`WDPR_RESTART_BIT];

  // Control register; restart bit self-clears one cycle after being set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `WDPR_CTRL_RST;
    end else if (wr_en && paddr == `WDPR_CTRL_OFF) begin
      ctrl_r <= pwdata[7:0];
    end else if (ctrl_r[`WDPR_RESTART_BIT]) begin
      ctrl_r[`WDPR_RESTART_BIT] <= 1'b0;
    end
  end

  // Machine-cycle divider from the system clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_r <= 4'h0;
    end else if (clr_all || !running) begin
      mc_r <= clr_all ? 4'h0 : mc_r;
    end else begin
      mc_r <= (mc_r == mc_last) ? 4'h0 : mc_r + 4'h1;
    end
  end

  // Prescaler stage selected by the control field.
  wdpr_prescale u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clr(clr_all),
    .tick_in(mc_tick),
    .sel(ctrl_r[`WDPR_PS_MSB:`WDPR_PS_LSB]),
    .tick_out(pre_tick)
  );

  // Main counter; wraps to zero on time-out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clr_all) begin
      cnt_r <= '0;
    end else if (pre_tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign timeout = pre_tick && (&cnt_r);

  // Reset request pulse, held one cycle after a time-out when enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= 1'b0;
    end else begin
      req_r <= timeout && ctrl_r[`WDPR_RST_EN_BIT];
    end
  end
  assign wdt_reset_req = req_r;

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 2'h0;
    end else begin
      if (wr_en && paddr == `WDPR_STAT_OFF) begin
        stat_r <= stat_r & ~pwdata[1:0];
      end
      if (timeout) begin
        stat_r[`WDPR_EV_TIMEOUT] <= 1'b1;
      end
      if (restart_ev) begin
        stat_r[`WDPR_EV_RESTART] <= 1'b1;
      end
    end
  end

  // Interrupt mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `WDPR_MASK_RST;
    end else if (wr_en && paddr == `WDPR_MASK_OFF) begin
      mask_r <= pwdata[1:0];
    end
  end
  assign wdt_irq = |(stat_r & mask_r);

  // Read data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `WDPR_CTRL_OFF: prdata_r <= {24'h0, ctrl_r};
        `WDPR_STAT_OFF: prdata_r <= {30'h0, stat_r};
        `WDPR_MASK_OFF: prdata_r <= {30'h0, mask_r};
        `WDPR_CNT_OFF: prdata_r <= 32'(cnt_r);
        default: prdata_r <= 32'h0;
      endcase
    end
  end
  assign prdata = prdata_r;
endmodule
`default_nettype wire

// ---- tb/wdpr_monitor.sv ----
// Checker for the watchdog core, tracking control state from the APB traffic.
// Assumes it is bound to every core instance.
`include "wdpr_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module wdpr_monitor #(
  parameter int CNT_BITS = 14
) (
  // Clock, reset and APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Processor state and outputs.
  input wire logic cpu_idle,
  input wire logic wdt_reset_req,
  input wire logic wdt_irq
);
  localparam int PSV [8] = '{2, 8, 4, 16, 32, 64, 128, 256};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ctl_r;
  logic [1:0] msk_r;
  logic v_r;
  int gap_r, age_r, per;
  wire logic rd = psel && penable && !pwrite;
  wire logic wc = psel && penable && pwrite && paddr == `WDPR_CTRL_OFF;
  // Expected interval of the current setting.
  assign per = (1 << CNT_BITS) * PSV[ctl_r[2:0]] * (ctl_r[3] ? 6 : 12);
  // Mirror the control and mask words; count cycles since writes and pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 8'h00;
      msk_r <= 2'h0;
      gap_r <= 0;
      age_r <= 0;
      v_r <= 1'b0;
    end else begin
      if (wc) ctl_r <= pwdata[7:0];
      if (psel && penable && pwrite && paddr == `WDPR_MASK_OFF) msk_r <= pwdata[1:0];
      age_r <= wc ? 0 : (age_r < 7 ? age_r + 1 : 7);
      gap_r <= (wc || wdt_reset_req) ? 1 : gap_r + 1;
      v_r <= wdt_reset_req ? !wc : (v_r && !wc && !cpu_idle);
    end
  end
  property p_req_pulse; wdt_reset_req |=> !wdt_reset_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("long reset request");
  property p_req_en; wdt_reset_req |-> $past(ctl_r[7]) && $past(ctl_r[5]); endproperty
  a_req_en: assert property (p_req_en) else $error("request while off");
  property p_req_idle; wdt_reset_req |-> !$past(cpu_idle) || $past(ctl_r[4]); endproperty
  a_req_idle: assert property (p_req_idle) else $error("request in idle");
  property p_period; wdt_reset_req && v_r |-> gap_r == per; endproperty
  a_period: assert property (p_period) else $error("wrong period");
  property p_restart_gap; wdt_reset_req && !v_r |-> gap_r >= per - 4; endproperty
  a_restart_gap: assert property (p_restart_gap) else $error("early request");
  property p_cnt_zero;
    rd && paddr == `WDPR_CNT_OFF && !ctl_r[7] && age_r > 2 |-> prdata == 32'h0;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero) else $error("count not held");
  property p_ctrl_read;
    rd && paddr == `WDPR_CTRL_OFF && age_r > 2 |-> prdata == {24'h0, ctl_r & 8'hBF};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("bad control read");
  property p_irq_mask; wdt_irq |-> msk_r != 2'h0; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
  cover property (wdt_reset_req && v_r);
  cover property (wdt_irq);
  cover property (cpu_idle && ctl_r[4] && wdt_reset_req);
endmodule

bind wdpr_core wdpr_monitor #(.CNT_BITS(CNT_BITS)) i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
  .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq));
`default_nettype wire

// ---- tb/wdpr_bench.sv ----
// Bench for the watchdog core: APB tasks, idle input and pulse timing checks.
// Assumes the core files and the checker are compiled first.
`include "wdpr_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module wdpr_bench;
  localparam int CB = 2;
  localparam int PSV [8] = '{2, 8, 4, 16, 32, 64, 128, 256};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_idle = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, wdt_reset_req, wdt_irq, err;
  int error_cnt = 0, checks = 0, cyc = 0, nreq = 0, n, n0;
  wdpr_core #(.CNT_BITS(CB)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .wdt_reset_req(wdt_reset_req),
    .wdt_irq(wdt_irq));
  // Clock, pulse counting and the run-time ceiling.
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (wdt_reset_req === 1'b1) nreq++;
    if (cyc == 95000) begin
      error_cnt++;
      test_done();
    end
  end
  // One APB transfer; read data lands in rd.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // Counts cycles up to the next reset request into n.
  task automatic wreq(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wdt_reset_req !== 1'b1 && n < lim);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `WDPR_CTRL_OFF, 0);
    chk("ctrl reset", 0, rd);
    apb(0, `WDPR_CNT_OFF, 0);
    chk("count reset", 0, rd);
    chk("mapped err", 0, err);
    apb(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    chk("unmapped err", 1, err);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      apb(1, `WDPR_CTRL_OFF, {24'h0, 4'b1110, 1'(i > 7), 3'(i)});
      wreq(70000);
      wreq(70000);
      chk("period", (1 << CB) * PSV[i % 8] * (i > 7 ? 6 : 12), n);
    end
    apb(1, `WDPR_CTRL_OFF, 0);
    apb(0, `WDPR_STAT_OFF, 0);
    chk("status", 3, rd);
    apb(1, `WDPR_MASK_OFF, 1);
    @(posedge pclk);
    chk("irq on", 1, wdt_irq);
    apb(1, `WDPR_MASK_OFF, 0);
    @(posedge pclk);
    chk("irq off", 0, wdt_irq);
    apb(1, `WDPR_STAT_OFF, 3);
    apb(0, `WDPR_STAT_OFF, 0);
    chk("status clr", 0, rd);
    $display("period test done");
    n0 = nreq;
    repeat (6) begin
      repeat (40) @(posedge pclk);
      apb(1, `WDPR_CTRL_OFF, 32'hE0);
    end
    chk("kicked", n0, nreq);
    apb(0, `WDPR_CTRL_OFF, 0);
    chk("restart clr", 32'hA0, rd);
    cpu_idle <= 1'b1;
    n0 = nreq;
    repeat (300) @(posedge pclk);
    chk("idle stop", n0, nreq);
    apb(1, `WDPR_CTRL_OFF, 32'hF0);
    wreq(200);
    chk("idle run", 1, n < 200);
    cpu_idle <= 1'b0;
    apb(1, `WDPR_CTRL_OFF, 32'h20);
    n0 = nreq;
    repeat (200) @(posedge pclk);
    apb(0, `WDPR_CNT_OFF, 0);
    chk("stopped cnt", 0, rd);
    chk("stopped", n0, nreq);
    apb(1, `WDPR_STAT_OFF, 3);
    apb(1, `WDPR_CTRL_OFF, 32'hC0);
    n0 = nreq;
    repeat (250) @(posedge pclk);
    chk("no reset req", n0, nreq);
    apb(0, `WDPR_STAT_OFF, 0);
    chk("timeout flag", 3, rd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `WDPR_CTRL_OFF, 0);
    chk("ctrl after reset", 0, rd);
    apb(0, `WDPR_CNT_OFF, 0);
    chk("count after reset", 0, rd);
    $display("reset enable and mid-run reset tests done");
    $display("restart idle stop tests done");
    test_done();
  end
endmodule
`default_nettype wire
